// ===== src/mul_pkg.sv
// Package for the multiply datapath: destination kinds, accumulator select, widths and timing.
// Assumes the core decoder presents one decoded multiply per cycle.
package mul_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LIT_W = 5;
  localparam int unsigned ACC_W = 40;
  localparam int unsigned REG_IDX_W = 4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned EXEC_CYCLES = 1;
  localparam int unsigned SFR_EXTRA_CYCLES = 1;
  localparam logic SIGN_RESET = 1'h0;

  // ---------------------------------------------------------------
  // Destination kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DEST_PAIR,
    DEST_SINGLE,
    DEST_ACC
  } dest_kind_t;

  // Accumulator select
  typedef enum logic {
    ACC_A,
    ACC_B
  } acc_sel_t;

endpackage

// ===== src/multiply_instruction_datapath.sv
// Multiply datapath of a 16-bit core: all multiply forms in one cycle.
// Assumes operands are read from the register file in the issue cycle and
// that the core's write-back accepts the results on the following edge.
// Pair upper index wraps modulo the register count.
//
// Contract
// [RULE1] Pair form: unsigned base times signed source, upper half to dest+1.
// [RULE2] Pair literal form: unsigned base times unsigned literal, full product to pair.
// [RULE3] Accumulator forms: register product, signedness from the sign suffix.
// [RULE4] Literal accumulator forms: base per suffix times unsigned five-bit literal.
// [RULE5] Single-word variant writes only one destination register, suffix signedness.
// [RULE6] Single-word literal form writes base times unsigned literal to one register.
// [RULE7] Every multiply form is one word and completes in one cycle.
// [RULE8] Multiplies leave all status flags unchanged.
// [RULE9] Reads of non-core special function registers add one cycle.
// [RULE10] Single-word destination keeps only the low sixteen product bits.
`timescale 1ns/1ns
module multiply_instruction_datapath
#(
  parameter int unsigned DATA_W = mul_pkg::WORD_W,
  parameter int unsigned ACC_WIDTH = mul_pkg::ACC_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  // Issue side
  input wire logic issue_valid,
  input wire logic base_signed,
  input wire logic source_signed,
  input wire logic use_short_literal,
  input wire mul_pkg::dest_kind_t dest_kind,
  input wire mul_pkg::acc_sel_t acc_sel,
  input wire logic [mul_pkg::REG_IDX_W-1:0] dest_idx,
  input wire logic [DATA_W-1:0] base_operand_reg,
  input wire logic [DATA_W-1:0] source_operand_reg,
  input wire logic [mul_pkg::LIT_W-1:0] short_literal,
  input wire logic sfr_access,
  input wire logic [7:0] status_in,
  // Results
  output logic issue_ready,
  output logic wr_lo_en,
  output logic [mul_pkg::REG_IDX_W-1:0] wr_lo_idx,
  output logic [DATA_W-1:0] wr_lo_data,
  output logic wr_hi_en,
  output logic [mul_pkg::REG_IDX_W-1:0] wr_hi_idx,
  output logic [DATA_W-1:0] wr_hi_data,
  output logic acc_wr_en,
  output mul_pkg::acc_sel_t acc_wr_sel,
  output logic [ACC_WIDTH-1:0] acc_wr_data,
  output logic [7:0] status_out,
  output logic done
);
  import mul_pkg::*;

  // ---------------------------------------------------------------
  // Operand extension
  // ---------------------------------------------------------------
  localparam int unsigned EXT_W = DATA_W + 1;
  localparam int unsigned PROD_W = 2 * EXT_W;

  logic [EXT_W-1:0] base_ext;
  logic [EXT_W-1:0] src_ext;
  logic signed [PROD_W-1:0] product;
  logic eff_base_signed;
  logic eff_src_signed;
  logic take;
  logic stall_q;

  // Literal forms always read the literal unsigned; base keeps its suffix
  assign eff_base_signed = base_signed; // see [RULE4]
  assign eff_src_signed = use_short_literal ? 1'h0 : source_signed; // see [RULE2] see [RULE6]

  // One extra sign bit lets one signed multiplier cover all four mixes
  assign base_ext = {eff_base_signed & base_operand_reg[DATA_W-1], base_operand_reg};
  assign src_ext = use_short_literal
    ? {{(EXT_W-LIT_W){1'h0}}, short_literal}
    : {eff_src_signed & source_operand_reg[DATA_W-1], source_operand_reg};
  assign product = $signed(base_ext) * $signed(src_ext); // see [RULE1] see [RULE3]

  // ---------------------------------------------------------------
  // Issue timing
  // ---------------------------------------------------------------
  logic stall_d;

  // A non-core SFR read holds issue for one added cycle
  assign issue_ready = ~(sfr_access & ~stall_q); // see [RULE9]
  assign take = issue_valid & issue_ready;
  // Set only by the refused first cycle, so the held request is taken next
  assign stall_d = issue_valid & sfr_access & ~stall_q; // see [RULE9]

  // Cleared on the take edge, so back-to-back SFR reads each pay once
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stall_q <= SIGN_RESET;
    end else begin
      stall_q <= stall_d;
    end
  end

  // ---------------------------------------------------------------
  // Register write-back
  // ---------------------------------------------------------------
  logic lo_en_d;
  logic lo_en_q;
  logic hi_en_d;
  logic hi_en_q;
  logic [REG_IDX_W-1:0] lo_idx_d;
  logic [REG_IDX_W-1:0] lo_idx_q;
  logic [REG_IDX_W-1:0] hi_idx_d;
  logic [REG_IDX_W-1:0] hi_idx_q;
  logic [DATA_W-1:0] lo_data_d;
  logic [DATA_W-1:0] lo_data_q;
  logic [DATA_W-1:0] hi_data_d;
  logic [DATA_W-1:0] hi_data_q;

  assign lo_en_d = take & (dest_kind != DEST_ACC); // see [RULE7]
  assign hi_en_d = take & (dest_kind == DEST_PAIR); // see [RULE5]
  assign lo_idx_d = dest_idx;
  assign hi_idx_d = dest_idx + REG_IDX_W'(1); // see [RULE1]
  // Single destination keeps the low word only
  assign lo_data_d = product[DATA_W-1:0]; // see [RULE10] see [RULE6]
  assign hi_data_d = product[2*DATA_W-1:DATA_W]; // see [RULE1] see [RULE2]

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lo_en_q <= 1'h0;
      hi_en_q <= 1'h0;
    end else begin
      lo_en_q <= lo_en_d;
      hi_en_q <= hi_en_d;
    end
  end

  // Index and data load every cycle; only the enables give them meaning
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lo_idx_q <= '0;
      hi_idx_q <= '0;
      lo_data_q <= '0;
      hi_data_q <= '0;
    end else begin
      lo_idx_q <= lo_idx_d;
      hi_idx_q <= hi_idx_d;
      lo_data_q <= lo_data_d;
      hi_data_q <= hi_data_d;
    end
  end

  assign wr_lo_en = lo_en_q;
  assign wr_hi_en = hi_en_q;
  assign wr_lo_idx = lo_idx_q;
  assign wr_hi_idx = hi_idx_q;
  assign wr_lo_data = lo_data_q;
  assign wr_hi_data = hi_data_q;

  // ---------------------------------------------------------------
  // Accumulator write-back
  // ---------------------------------------------------------------
  logic acc_en_d;
  logic acc_en_q;
  acc_sel_t acc_sel_d;
  acc_sel_t acc_sel_q;
  logic [ACC_WIDTH-1:0] acc_data_d;
  logic [ACC_WIDTH-1:0] acc_data_q;

  assign acc_en_d = take & (dest_kind == DEST_ACC); // see [RULE3] see [RULE4]
  assign acc_sel_d = acc_sel;
  // Product sign-extended into the guard bits of the accumulator
  assign acc_data_d = ACC_WIDTH'(product); // see [RULE3]

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_en_q <= 1'h0;
    end else begin
      acc_en_q <= acc_en_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_sel_q <= ACC_A;
      acc_data_q <= '0;
    end else begin
      acc_sel_q <= acc_sel_d;
      acc_data_q <= acc_data_d;
    end
  end

  assign acc_wr_en = acc_en_q;
  assign acc_wr_sel = acc_sel_q;
  assign acc_wr_data = acc_data_q;

  // ---------------------------------------------------------------
  // Status and completion
  // ---------------------------------------------------------------
  logic [7:0] status_d;
  logic [7:0] status_q;
  logic done_d;
  logic done_q;

  assign status_d = status_in; // see [RULE8]
  assign done_d = take; // see [RULE7]

  // Flags pass one register and nothing here ever writes them
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d; // see [RULE8]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      done_q <= 1'h0;
    end else begin
      done_q <= done_d; // see [RULE7]
    end
  end

  assign status_out = status_q;
  assign done = done_q;

endmodule // multiply_instruction_datapath

// ===== tb/mul_props.sv
// Assertions on the multiply datapath ports.
// Bound into multiply_instruction_datapath; sees its ports only.
`timescale 1ns/1ns
module mul_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic issue_valid,
  input wire logic use_short_literal,
  input wire mul_pkg::dest_kind_t dest_kind,
  input wire mul_pkg::acc_sel_t acc_sel,
  input wire logic [3:0] dest_idx,
  input wire logic [15:0] base_operand_reg,
  input wire logic [15:0] source_operand_reg,
  input wire logic [4:0] short_literal,
  input wire logic sfr_access,
  input wire logic [7:0] status_in,
  input wire logic issue_ready,
  input wire logic wr_lo_en,
  input wire logic [15:0] wr_lo_data,
  input wire logic [3:0] wr_lo_idx,
  input wire logic wr_hi_en,
  input wire logic [3:0] wr_hi_idx,
  input wire logic acc_wr_en,
  input wire mul_pkg::acc_sel_t acc_wr_sel,
  input wire logic [7:0] status_out,
  input wire logic done
);
  import mul_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire take = issue_valid && issue_ready;
  // Low word is the same for every signedness
  wire [15:0] low_prod = base_operand_reg *
    (use_short_literal ? {11'h0, short_literal} : source_operand_reg);
  done_lat_a: assert property (take |=> done) else $error("done missing");
  flag_keep_a: assert property ($past(reset_n) |->
    status_out == $past(status_in)) else $error("flags changed");
  sfr_wait_a: assert property (issue_valid && sfr_access && !issue_ready |=>
    issue_ready) else $error("sfr stall too long");
  sfr_cost_a: assert property (take && sfr_access |-> !$past(issue_ready))
    else $error("sfr taken early");
  pair_write_a: assert property (take && dest_kind == DEST_PAIR |=>
    wr_lo_en && wr_hi_en && wr_hi_idx == $past(dest_idx) + 4'h1) else $error("pair");
  single_write_a: assert property (take && dest_kind == DEST_SINGLE |=>
    wr_lo_en && !wr_hi_en && !acc_wr_en) else $error("single");
  acc_write_a: assert property (take && dest_kind == DEST_ACC |=>
    acc_wr_en && !wr_lo_en && acc_wr_sel == $past(acc_sel)) else $error("acc");
  lo_data_a: assert property (take && dest_kind != DEST_ACC |=>
    wr_lo_data == $past(low_prod) && wr_lo_idx == $past(dest_idx)) else $error("low word");
  cover property (take && dest_kind == DEST_PAIR);
  cover property (take && dest_kind == DEST_SINGLE && use_short_literal);
  cover property (take && dest_kind == DEST_ACC);
  cover property (take && sfr_access);
endmodule // mul_props

bind multiply_instruction_datapath mul_props chk (.*);

// ===== tb/tb.sv
// Random multiply stream with a queue of expected results.
// Assumes the datapath and mul_props are compiled first.
`timescale 1ns/1ns
module tb;
  import mul_pkg::*;
  logic core_clk = '0, reset_n = '0, issue_valid = '0, base_signed = '0, source_signed = '0;
  logic use_short_literal = '0, sfr_access = '0, issue_ready, wr_lo_en, wr_hi_en, acc_wr_en, done;
  dest_kind_t dest_kind = DEST_PAIR;
  acc_sel_t acc_sel = ACC_A, acc_wr_sel;
  logic [3:0] dest_idx = '0, wr_lo_idx, wr_hi_idx;
  logic [15:0] base_operand_reg = '0, source_operand_reg = '0, wr_lo_data, wr_hi_data;
  logic [4:0] short_literal = '0;
  logic [7:0] status_in = '0, status_out;
  logic [39:0] acc_wr_data;
  logic [71:0] notes[$];
  int fails = 0, checked = 0;
  multiply_instruction_datapath dut (.*);
  initial forever #4 core_clk = ~core_clk;
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // Results: words whose enable is low are masked to zero before the compare
  // ----
  logic [71:0] result_word;
  assign result_word = {wr_lo_en ? wr_lo_data : 16'h0, wr_hi_en ? wr_hi_data : 16'h0,
    acc_wr_en ? acc_wr_data : 40'h0};
  always @(posedge core_clk) if (reset_n && done === 1'h1) begin
    check(result_word, notes.pop_front());
  end
  initial begin
    logic signed [16:0] b, s;
    logic signed [39:0] p;
    logic [31:0] r1, r2;
    dest_kind_t k;
    void'($urandom(32'hA42F725B));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    repeat (300) begin
      r1 = $urandom;
      r2 = $urandom;
      k = dest_kind_t'(r2[22:21] % 2'h3);
      b = r2[17] ? {r1[15], r1[15:0]} : {1'h0, r1[15:0]};
      s = r2[19] ? {12'h0, r2[4:0]} : {r2[18] & r1[31], r1[31:16]};
      p = b * s;
      notes.push_back(k == DEST_ACC ? {32'h0, p} :
        {p[15:0], k == DEST_PAIR ? p[31:16] : 16'h0, 40'h0});
      {status_in, dest_idx, short_literal} <= r2[16:0];
      {source_operand_reg, base_operand_reg} <= r1;
      {use_short_literal, source_signed, base_signed} <= r2[19:17];
      acc_sel <= acc_sel_t'(r2[20]);
      dest_kind <= k;
      sfr_access <= r2[25:23] == 3'h0;
      issue_valid <= 1'h1;
      #1 while (!issue_ready) @(posedge core_clk) #1;
      @(posedge core_clk);
    end
    issue_valid <= 1'h0;
    repeat (3) @(posedge core_clk);
    check(72'(notes.size()), 72'h0);
    wrap_up;
  end
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
endmodule // tb
